//--- pkg/prog_msg_pkg.sv
// constants and types shared by the stored program message interpreter
package prog_msg_pkg;
  // message types carried in payload byte 1
  localparam logic [7:0] MSG_TYPE_BUF  = 8'h01;
  localparam logic [7:0] MSG_TYPE_IMM  = 8'h02;
  // opcodes carried in payload byte 2
  localparam logic [7:0] OP_SEG_START  = 8'h78;
  localparam logic [7:0] OP_PROG_STOP  = 8'h98;
  localparam logic [7:0] OP_UREG_READ  = 8'h9a;
  localparam logic [7:0] OP_PARAM_WR   = 8'h83;
  localparam logic [7:0] OP_PARAM_RD   = 8'h84;
  localparam logic [7:0] OP_PREG_WR    = 8'h9e;
  localparam logic [7:0] OP_BUF_LOAD   = 8'h79;
  localparam logic [7:0] OP_BUF_SAVE   = 8'h7a;
  localparam logic [7:0] OP_MAINT_PORT = 8'hff;
  // operands
  localparam logic [7:0] OPD_VELOCITY  = 8'h1d;
  localparam logic [7:0] OPD_STATUS    = 8'h80;
  localparam logic [7:0] OPD_PORT_RST  = 8'h01;
  localparam logic [7:0] OPD_PORT_OPEN = 8'h00;
  localparam logic [7:0] OPD_DEC_QUICK = 8'h00;
  localparam logic [7:0] OPD_DEC_NORM  = 8'h01;
  // storage sizes
  localparam int         NUM_SEGS      = 12;
  localparam int         SEG_LINES     = 16;
  localparam int         NUM_UREGS     = 10;
  localparam int         NUM_PREGS     = 64;
  localparam int         STAT_RUN_BIT  = 14;
  localparam logic [3:0] SEG_MAX       = 4'hc;
  localparam logic [3:0] UREG_LAST     = 4'h9;
  // response status codes
  localparam logic [15:0] ST_OK        = 16'h0000;
  localparam logic [15:0] ST_BAD_PARAM = 16'h0020;
  localparam logic [15:0] ST_STATE     = 16'h0010;
  localparam logic [15:0] ST_NO_SVC    = 16'h0008;
  localparam logic [15:0] ST_RESOURCE  = 16'h0002;
  // reset values
  localparam logic [15:0] VEL_RST      = 16'h0000;
  // program line: message type, opcode, operand, data
  typedef struct packed {
    logic [7:0]  mtype;
    logic [7:0]  op;
    logic [7:0]  opd;
    logic [31:0] data;
  } line_s;
  localparam logic [55:0] LINE_EMPTY   = 56'h0;
endpackage

//--- pkg/line_if.sv
// program line fetch path between the interpreter and the store
`timescale 1ns/100ps
interface line_if;
  import prog_msg_pkg::*;
  logic        wr_en;
  logic [3:0]  wr_seg;
  logic [3:0]  wr_line;
  line_s       wr_data;
  logic [3:0]  rd_seg;
  logic [3:0]  rd_line;
  line_s       rd_data;
  modport ctrl  (output wr_en, wr_seg, wr_line, wr_data, rd_seg, rd_line, input rd_data);
  modport store (input wr_en, wr_seg, wr_line, wr_data, rd_seg, rd_line, output rd_data);
endinterface

//--- rtl/seg_store.sv
// stored program segment memory
`timescale 1ns/100ps
module seg_store
  import prog_msg_pkg::*;
(
  // clock and control
  input  wire logic clk,
  input  wire logic ce,
  // line access
  line_if.store     lp
);
  // slot 0 is the load buffer, slots 1 to 12 the stored segments
  line_s mem_reg [(NUM_SEGS + 1) * SEG_LINES];
  wire [7:0] wr_idx = {lp.wr_seg, lp.wr_line};
  wire [7:0] rd_idx = {lp.rd_seg, lp.rd_line};

  // write port, read is combinational
  always_ff @(posedge clk) begin
    if (ce && lp.wr_en) begin
      mem_reg[wr_idx] <= lp.wr_data;
    end
  end
  assign lp.rd_data = (rd_idx < 8'((NUM_SEGS + 1) * SEG_LINES)) ? mem_reg[rd_idx]
                                                                : line_s'(LINE_EMPTY);
endmodule // seg_store

//--- rtl/prog_msg_ctrl.sv
// stored program message interpreter
`timescale 1ns/100ps
module prog_msg_ctrl
  import prog_msg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // command payload
  input  wire logic        cmd_valid,
  input  wire logic [63:0] cmd_payload,
  // response payload
  output logic             rsp_valid,
  output logic [63:0]      rsp_payload,
  // motion engine
  output logic             move_start,
  output logic [7:0]       move_op,
  output logic [31:0]      move_data,
  output logic [15:0]      move_velocity,
  input  wire logic        move_busy,
  output logic             stop_req,
  output logic             stop_quick,
  // program register port
  output logic             preg_wr,
  output logic [7:0]       preg_addr,
  output logic [31:0]      preg_data,
  // maintenance port
  input  wire logic        maint_connect,
  output logic             maint_open,
  output logic             maint_conn,
  // status
  output logic             prog_running
);
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_FETCH = 2'b01,
    RUN_EXEC  = 2'b10,
    RUN_WAIT  = 2'b11
  } run_e;

  line_if lp();
  seg_store u_store (
    .clk (clk),
    .ce  (ce),
    .lp  (lp)
  );

  // payload fields, byte 0 first in the top bits
  wire [7:0]  f_res   = cmd_payload[63:56];
  wire [7:0]  f_type  = cmd_payload[55:48];
  wire [7:0]  f_op    = cmd_payload[47:40];
  wire [7:0]  f_opd   = cmd_payload[39:32];
  wire [31:0] f_data  = cmd_payload[31:0];
  wire [3:0]  f_seg   = cmd_payload[3:0];

  run_e        run_reg, run_next;
  logic [3:0]  seg_reg;
  logic [3:0]  line_reg;
  logic [3:0]  ret_seg_reg;
  logic [3:0]  ret_line_reg;
  logic        ret_ok_reg;
  logic        loading_reg;
  logic [3:0]  ld_line_reg;
  logic        ld_over_reg;
  logic [15:0] vel_pend_reg;
  logic        copy_reg;
  logic [3:0]  cp_seg_reg;
  logic [3:0]  cp_line_reg;
  logic [31:0] ureg_reg [NUM_UREGS];

  // line fetch address; a save borrows the port to read the load buffer in slot 0
  assign lp.rd_seg  = copy_reg ? 4'h0 : seg_reg;
  assign lp.rd_line = copy_reg ? cp_line_reg : line_reg;
  line_s cur;
  assign cur = lp.rd_data;

  // accepted messages by class
  function automatic logic is_op(input logic [7:0] t, input logic [7:0] o,
                                 input logic [7:0] want);
    return (t == MSG_TYPE_IMM) && (o == want);
  endfunction

  wire running   = (run_reg != RUN_IDLE);
  wire take      = ce && cmd_valid;
  wire t_buf     = take && (f_type == MSG_TYPE_BUF);
  wire buf_block = t_buf && running;
  wire buf_store = t_buf && !running && loading_reg && !ld_over_reg;
  wire buf_exec  = t_buf && !running && !loading_reg;
  wire c_start   = take && is_op(f_type, f_op, OP_SEG_START);
  wire seg_ok    = (f_data[7:4] == 4'h0) && (f_seg != 4'h0) && (f_seg <= SEG_MAX);
  wire c_stop    = take && is_op(f_type, f_op, OP_PROG_STOP);
  wire c_uread   = take && is_op(f_type, f_op, OP_UREG_READ);
  wire c_pwr     = take && is_op(f_type, f_op, OP_PARAM_WR);
  wire c_prd     = take && is_op(f_type, f_op, OP_PARAM_RD);
  wire c_qwr     = take && is_op(f_type, f_op, OP_PREG_WR);
  wire c_load    = take && is_op(f_type, f_op, OP_BUF_LOAD);
  wire c_save    = take && is_op(f_type, f_op, OP_BUF_SAVE);
  wire c_maint   = take && is_op(f_type, f_op, OP_MAINT_PORT);
  wire ureg_ok   = f_opd[3:0] <= UREG_LAST && f_opd[7:4] == 4'h0;
  wire vel_upd   = c_pwr && (f_opd == OPD_VELOCITY);
  wire stat_upd  = c_prd && (f_opd == OPD_STATUS);
  wire save_ok   = c_save && !running && seg_ok && !copy_reg;
  wire start_ok  = c_start && seg_ok && !running && !copy_reg;
  wire cp_keep   = {1'b0, cp_line_reg} < {ld_over_reg, ld_line_reg}; // loaded lines only

  // status word, bit 14 follows execution
  wire [15:0] status_word = 16'(running) << STAT_RUN_BIT;

  // line executed by the program
  wire line_empty = (cur == line_s'(LINE_EMPTY));
  wire line_call  = (cur.op == OP_SEG_START) && (cur.data[3:0] != 4'h0)
                    && (cur.data[3:0] <= SEG_MAX);
  wire line_ureg  = (cur.op == OP_PREG_WR) && (cur.opd[7:4] == 4'h0)
                    && (cur.opd[3:0] <= UREG_LAST);
  wire line_last  = (line_reg == 4'(SEG_LINES - 1));
  // an empty line returns to the line after the latest call, if that call did not stand on line 15 and no return has followed it, instead of ending the program
  wire ret_hold   = line_empty && ret_ok_reg;

  // sequencer next state
  always_comb begin
    run_next = run_reg;
    case (run_reg)
      RUN_IDLE:  if (start_ok) run_next = RUN_FETCH;
      RUN_FETCH: run_next = !line_empty ? RUN_EXEC : (ret_hold ? RUN_FETCH : RUN_IDLE);
      RUN_EXEC:  run_next = line_call ? RUN_FETCH : RUN_WAIT;
      RUN_WAIT:  if (!move_busy) run_next = line_last ? RUN_IDLE : RUN_FETCH;
      default:   run_next = RUN_IDLE;
    endcase
    if (c_stop) run_next = RUN_IDLE;
  end

  // response status by command
  logic [15:0] rsp_code;
  always_comb begin
    rsp_code = ST_OK;
    if (buf_block)                                rsp_code = ST_STATE;
    else if (t_buf && loading_reg && ld_over_reg) rsp_code = ST_RESOURCE;
    else if (c_start && !seg_ok)                  rsp_code = ST_BAD_PARAM;
    else if (c_start && (running || copy_reg))    rsp_code = ST_STATE;
    else if (c_load && (running || copy_reg))     rsp_code = ST_STATE;
    else if (c_uread && ureg_ok)                  rsp_code = ureg_reg[f_opd[3:0]][15:0];
    else if (c_uread)                             rsp_code = ST_BAD_PARAM;
    else if (stat_upd)                            rsp_code = status_word;
    else if (c_save && !save_ok)                  rsp_code = ST_BAD_PARAM;
    else if (c_maint && f_opd > OPD_PORT_RST)     rsp_code = ST_BAD_PARAM;
    else if (f_type != MSG_TYPE_BUF && !(c_start || c_stop || c_uread || c_pwr
             || c_prd || c_qwr || c_load || c_save || c_maint)) rsp_code = ST_NO_SVC;
  end

  // response register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid   <= 1'b0;
      rsp_payload <= 64'h0;
    end else if (ce) begin
      rsp_valid   <= cmd_valid;
      if (cmd_valid) begin
        rsp_payload <= {f_res, f_type, f_op, f_opd, rsp_code, 16'h0};
      end
    end
  end

  // sequencer and program position
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_reg      <= RUN_IDLE;
      seg_reg      <= 4'h0;
      line_reg     <= 4'h0;
      ret_seg_reg  <= 4'h0;
      ret_line_reg <= 4'h0;
      ret_ok_reg   <= 1'b0;
    end else if (ce) begin
      run_reg <= run_next;
      if (start_ok) begin
        seg_reg    <= f_seg;
        line_reg   <= 4'h0;
        ret_ok_reg <= 1'b0;
      end else if (run_reg == RUN_EXEC && line_call) begin
        ret_seg_reg  <= seg_reg;
        ret_line_reg <= line_reg + 4'h1;
        ret_ok_reg   <= !line_last;
        seg_reg      <= cur.data[3:0];
        line_reg     <= 4'h0;
      end else if (run_reg == RUN_FETCH && line_empty && ret_ok_reg) begin
        seg_reg    <= ret_seg_reg;
        line_reg   <= ret_line_reg;
        ret_ok_reg <= 1'b0;
      end else if (run_reg == RUN_WAIT && !move_busy && !line_last) begin
        line_reg <= line_reg + 4'h1;
      end
    end
  end

  // motion outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      move_start    <= 1'b0;
      move_op       <= 8'h0;
      move_data     <= 32'h0;
      move_velocity <= VEL_RST;
      vel_pend_reg  <= VEL_RST;
      stop_req      <= 1'b0;
      stop_quick    <= 1'b0;
    end else if (ce) begin
      move_start <= 1'b0;
      stop_req   <= c_stop && running;
      if (c_stop) begin
        stop_quick <= (f_opd == OPD_DEC_QUICK);
      end
      if (vel_upd) begin
        vel_pend_reg <= f_data[15:0];
      end
      if (run_reg == RUN_EXEC && !line_call) begin
        move_start    <= 1'b1;
        move_op       <= cur.op;
        move_data     <= cur.data;
        move_velocity <= vel_pend_reg;
      end else if (buf_exec) begin
        move_start    <= 1'b1;
        move_op       <= f_op;
        move_data     <= f_data;
        move_velocity <= vel_pend_reg;
      end
    end
  end

  // program register writes from host commands only, no range check
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preg_wr   <= 1'b0;
      preg_addr <= 8'h0;
      preg_data <= 32'h0;
    end else if (ce) begin
      preg_wr <= c_qwr;
      if (c_qwr) begin
        preg_addr <= f_opd;
        preg_data <= f_data;
      end
    end
  end

  // user registers written by host or program line
  generate
    for (genvar i = 0; i < NUM_UREGS; i++) begin : g_ureg
      wire host_wr = c_qwr && f_opd == 8'(i);
      wire prog_wr = run_reg == RUN_EXEC && line_ureg && cur.opd == 8'(i);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ureg_reg[i] <= 32'h0;
        end else if (ce && host_wr) begin
          ureg_reg[i] <= f_data;
        end else if (ce && prog_wr) begin
          ureg_reg[i] <= cur.data;
        end
      end
    end
  endgenerate

  // download buffer; load buffer is segment slot 0
  assign lp.wr_en   = ce && (buf_store || copy_reg);
  assign lp.wr_seg  = copy_reg ? cp_seg_reg : 4'h0;
  assign lp.wr_line = copy_reg ? cp_line_reg : ld_line_reg;
  assign lp.wr_data = (copy_reg && cp_keep) ? cur
                      : copy_reg ? line_s'(LINE_EMPTY)
                      : line_s'({f_type, f_op, f_opd, f_data});
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loading_reg <= 1'b0;
      ld_line_reg <= 4'h0;
      ld_over_reg <= 1'b0;
    end else if (ce) begin
      if (c_load && !running && !copy_reg) begin
        loading_reg <= 1'b1;
        ld_line_reg <= 4'h0;
        ld_over_reg <= 1'b0;
      end else if (buf_store) begin
        ld_line_reg <= ld_line_reg + 4'h1;
        ld_over_reg <= (ld_line_reg == 4'(SEG_LINES - 1));
      end else if (save_ok) begin
        loading_reg <= 1'b0;
      end
    end
  end

  // save copies the buffer into the target, one line a cycle; unloaded lines end empty
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      copy_reg    <= 1'b0;
      cp_seg_reg  <= 4'h0;
      cp_line_reg <= 4'h0;
    end else if (ce) begin
      if (save_ok) begin
        copy_reg    <= 1'b1;
        cp_seg_reg  <= f_seg;
        cp_line_reg <= 4'h0;
      end else if (copy_reg) begin
        copy_reg    <= (cp_line_reg != 4'(SEG_LINES - 1));
        cp_line_reg <= cp_line_reg + 4'h1;
      end
    end
  end

  // maintenance port: open after reset, closed by FF/1, reopened by FF/0
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      maint_open <= 1'b1;
      maint_conn <= 1'b0;
    end else if (ce) begin
      if (c_maint && f_opd == OPD_PORT_RST) begin
        maint_open <= 1'b0;
        maint_conn <= 1'b0;
      end else if (c_maint && f_opd == OPD_PORT_OPEN) begin
        maint_open <= 1'b1;
      end else if (maint_open && maint_connect && !maint_conn) begin
        maint_conn <= 1'b1;
        maint_open <= 1'b0;
      end
    end
  end

  // running flag out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_running <= 1'b0;
    end else if (ce) begin
      prog_running <= (run_next != RUN_IDLE);
    end
  end
endmodule // prog_msg_ctrl

//--- tb/prog_msg_ctrl_chk.sv
// assertions on the command, response and side ports of the interpreter
`timescale 1ns/100ps
module prog_msg_chk
  import prog_msg_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // command and response
  input wire logic        ce,
  input wire logic        cmd_valid,
  input wire logic [63:0] cmd_payload,
  input wire logic        rsp_valid,
  input wire logic [63:0] rsp_payload,
  // side outputs
  input wire logic        stop_req,
  input wire logic        stop_quick,
  input wire logic        preg_wr,
  input wire logic [7:0]  preg_addr,
  input wire logic        move_start,
  input wire logic [15:0] move_velocity,
  input wire logic        maint_open,
  input wire logic        maint_conn,
  input wire logic        prog_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // command decode
  wire        tk = ce && cmd_valid;
  wire        t2 = tk && cmd_payload[55:48] == MSG_TYPE_IMM;
  wire [7:0]  op = cmd_payload[47:40];
  wire [7:0]  od = cmd_payload[39:32];
  wire [7:0]  sg = cmd_payload[7:0];
  wire [15:0] st = rsp_payload[31:16];
  rsp_echo_a: assert property (tk |=> rsp_valid && rsp_payload[15:0] == 16'h0 &&
    rsp_payload[63:32] == $past(cmd_payload[63:32])) else $error("response not echoed");
  start_run_a: assert property (t2 && op == OP_SEG_START && sg != 0 && sg <= 12 &&
    !prog_running |=> prog_running && st == ST_OK) else $error("segment did not start");
  bad_seg_a: assert property (t2 && op == OP_SEG_START && (sg == 0 || sg > 12)
    |=> st == ST_BAD_PARAM) else $error("bad segment accepted");
  busy_refuse_a: assert property (tk && cmd_payload[55:48] == MSG_TYPE_BUF &&
    prog_running |=> st == ST_STATE) else $error("buffered command taken while running");
  stop_run_a: assert property (t2 && op == OP_PROG_STOP && prog_running
    |=> stop_req && stop_quick == ($past(od) == OPD_DEC_QUICK)) else $error("stop wrong");
  status_rd_a: assert property (t2 && op == OP_PARAM_RD && od == OPD_STATUS
    |=> st == {1'b0, $past(prog_running), 14'h0}) else $error("status word wrong");
  ureg_range_a: assert property (t2 && op == OP_UREG_READ && od > 9
    |=> st == ST_BAD_PARAM) else $error("user register range not refused");
  preg_write_a: assert property (t2 && op == OP_PREG_WR
    |=> preg_wr && preg_addr == $past(od)) else $error("register write not issued");
  vel_hold_a: assert property ($changed(move_velocity) |-> move_start)
    else $error("velocity changed outside a move start");
  port_drop_a: assert property (t2 && op == OP_MAINT_PORT && od == OPD_PORT_RST
    |=> !maint_conn && !maint_open) else $error("port not closed");
  port_open_a: assert property (t2 && op == OP_MAINT_PORT && od == OPD_PORT_OPEN
    |=> maint_open) else $error("port not reopened");
  one_host_a: assert property ($rose(maint_conn) |-> $past(maint_open))
    else $error("connection taken while port closed");
endmodule // prog_msg_chk

bind prog_msg_ctrl prog_msg_chk chk_i (.clk, .rst_n, .ce, .cmd_valid, .cmd_payload,
  .rsp_valid, .rsp_payload, .stop_req, .stop_quick, .preg_wr, .preg_addr, .move_start,
  .move_velocity, .maint_open, .maint_conn, .prog_running);

//--- tb/net_host_model.sv
// network host that issues command payloads and collects responses
`timescale 1ns/100ps
module net_host_model
  import prog_msg_pkg::*;
(
  // clock
  input wire logic        clk,
  // command and response
  output logic            cmd_valid,
  output logic [63:0]     cmd_payload,
  input wire logic        rsp_valid,
  input wire logic [63:0] rsp_payload
);
  initial begin
    cmd_valid   = 1'b0;
    cmd_payload = 64'h0;
  end
  // segment start with the segment number in the last byte
  function automatic logic [63:0] seg(input logic [7:0] n);
    return {8'h0, MSG_TYPE_IMM, OP_SEG_START, 8'h01, 24'h0, n};
  endfunction
  // present one payload from a falling edge, collect the answer a cycle later
  task automatic send(input logic [63:0] p, output logic [63:0] r, output logic v);
    cmd_valid   = 1'b1;
    cmd_payload = p;
    @(posedge clk);
    @(negedge clk);
    v = rsp_valid;
    r = rsp_payload;
  endtask
  // release the strobe; payload lines stop showing the last value
  task automatic rest();
    cmd_valid   = 1'b0;
    cmd_payload = ~cmd_payload;
    @(negedge clk);
  endtask
endmodule // net_host_model

//--- tb/stored_program_message_control_tb_top.sv
// self-checking bench for the stored program message interpreter
`timescale 1ns/100ps
module stored_program_message_control_tb_top;
  import prog_msg_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        cmd_valid;
  logic [63:0] cmd_payload;
  logic        move_busy;
  logic        maint_connect;
  logic        rsp_valid;
  logic [63:0] rsp_payload;
  logic        move_start;
  logic [15:0] move_velocity;
  logic [7:0]  move_op;
  logic [31:0] move_data;
  logic        stop_req;
  logic        stop_quick;
  logic        preg_wr;
  logic [7:0]  preg_addr;
  logic [31:0] preg_data;
  logic        maint_open;
  logic        maint_conn;
  logic        prog_running;
  int          failures;
  int          total_checks;
  localparam logic [7:0] I = MSG_TYPE_IMM;
  localparam logic [7:0] B = MSG_TYPE_BUF;
  // design and host
  prog_msg_ctrl dut (.clk, .rst_n, .ce, .cmd_valid, .cmd_payload, .rsp_valid, .rsp_payload,
    .move_start, .move_op, .move_data, .move_velocity, .move_busy, .stop_req,
    .stop_quick, .preg_wr, .preg_addr, .preg_data, .maint_connect, .maint_open,
    .maint_conn, .prog_running);
  net_host_model host (.clk, .cmd_valid, .cmd_payload, .rsp_valid, .rsp_payload);
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // motion engine stays busy one cycle after each issued move
  always @(negedge clk) move_busy <= move_start;
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [63:0] m(input logic [7:0] t, o, d, input logic [31:0] x);
    return {8'h0, t, o, d, x};
  endfunction
  // one command and its whole response
  task automatic cmd(input logic [63:0] p, input logic [15:0] st);
    logic [63:0] r;
    logic        v;
    host.send(p, r, v);
    check("rsp_valid", v, 1);
    check("rsp", r, {p[63:32], st, 16'h0});
  endtask
  // bounded wait for the program to stop
  task automatic settle();
    host.rest();
    for (int i = 0; i < 200 && prog_running !== 1'b0; i++) @(negedge clk);
    check("stopped", prog_running, 0);
    if (prog_running !== 1'b0) finish_test();
  endtask
  task automatic t_buffer();
    cmd(m(I, OP_BUF_LOAD, 0, 0), ST_OK);
    for (int i = 0; i < SEG_LINES; i++) cmd(m(B, 8'h66, i[7:0], 32'h10), ST_OK);
    cmd(m(B, 8'h66, 0, 0), ST_RESOURCE);
    cmd(m(I, OP_BUF_SAVE, 0, 1), ST_OK);
    host.rest();
    repeat (SEG_LINES) @(negedge clk); // copy into segment 1
    cmd(m(I, OP_BUF_LOAD, 0, 0), ST_OK);
    cmd(m(B, OP_SEG_START, 0, 1), ST_OK);
    cmd(m(I, OP_BUF_SAVE, 0, 12), ST_OK);
    host.rest();
    repeat (SEG_LINES) @(negedge clk);
  endtask
  task automatic t_start();
    cmd(host.seg(1), ST_OK);
    check("running", prog_running, 1);
    cmd(m(I, OP_PARAM_RD, OPD_STATUS, 0), 16'h4000);
    cmd(m(B, 8'h66, 0, 0), ST_STATE);
    settle();
    cmd(m(I, OP_PARAM_RD, OPD_STATUS, 0), ST_OK);
    cmd(host.seg(0), ST_BAD_PARAM);
    cmd(host.seg(13), ST_BAD_PARAM);
    cmd(host.seg(12), ST_OK);
    host.rest();
    repeat (6) @(negedge clk); // segment 12 alone would have ended by now
    check("called", prog_running, 1);
    check("call_line", move_op, 8'h66);
    settle();
  endtask
  task automatic t_stop();
    for (int q = 0; q < 2; q++) begin
      cmd(host.seg(1), ST_OK);
      cmd(m(I, OP_PROG_STOP, q[7:0], 0), ST_OK);
      check("stop_req", stop_req, 1);
      check("stop_quick", stop_quick, q == 0);
      settle();
    end
  endtask
  task automatic t_regs();
    cmd(host.seg(1), ST_OK);
    cmd(m(I, OP_PREG_WR, 8'h4a, 32'hffffffff), ST_OK);
    check("preg_wr", preg_wr, 1);
    check("preg_addr", preg_addr, 8'h4a);
    check("preg_data", preg_data, 32'hffffffff);
    settle();
    cmd(m(I, OP_UREG_READ, 8'h0a, 0), ST_BAD_PARAM);
    cmd(m(I, OP_PARAM_WR, OPD_VELOCITY, 32'h1234), ST_OK);
    check("velocity", move_velocity, VEL_RST);
    cmd(m(B, 8'h66, 0, 32'h20), ST_OK);
    check("velocity_next", move_velocity, 16'h1234);
    check("move_op", move_op, 8'h66);
    check("move_data", move_data, 32'h20);
    cmd(m(I, OP_PREG_WR, 8'h03, 32'h00005a5a), ST_OK);
    cmd(m(I, OP_UREG_READ, 8'h03, 0), 16'h5a5a);
    cmd(m(I, 8'h55, 0, 0), ST_NO_SVC);
    host.rest();
  endtask
  task automatic t_maint();
    logic [63:0] r;
    logic        v;
    maint_connect = 1'b1;
    repeat (2) @(negedge clk); // host stays quiet while the computer attaches
    check("conn", maint_conn, 1);
    cmd(m(I, OP_MAINT_PORT, OPD_PORT_RST, 0), ST_OK);
    check("conn_open", {maint_conn, maint_open}, 0);
    host.rest();
    repeat (2) @(negedge clk);
    check("conn", maint_conn, 0);
    cmd(m(I, OP_MAINT_PORT, OPD_PORT_OPEN, 0), ST_OK);
    check("open", maint_open, 1);
    host.rest();
    repeat (2) @(negedge clk);
    check("conn", maint_conn, 1);
    ce = 1'b0;
    host.send(m(I, OP_MAINT_PORT, OPD_PORT_RST, 0), r, v);
    check("frozen", {maint_conn, maint_open}, 2'b10);
    ce = 1'b1;
    host.rest();
  endtask
  // main sequence
  initial begin
    failures      = 0;
    total_checks  = 0;
    rst_n         = 1'b0;
    ce            = 1'b1;
    maint_connect = 1'b0;
    move_busy     = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check("rst", {rsp_valid, maint_open, prog_running, move_velocity}, 19'h20000);
    t_buffer();
    t_start();
    t_stop();
    t_regs();
    t_maint();
    finish_test();
  end
endmodule // stored_program_message_control_tb_top
